/* include/fls_defs.vh */
// constants for the link state and fabric service framer
`ifndef FLS_DEFS_VH
`define FLS_DEFS_VH
`define FLS_FC_ADDR       24'hfffffd
`define FLS_CMD_LSU       32'h15000000
`define FLS_CMD_LSA       32'h16000000
`define FLS_CMD_BF        32'h01700000
`define FLS_CMD_RCF       32'h18000000
`define FLS_ACC_WORD      32'h00200000
`define FLS_FSPF_VER      8'h02
`define FLS_AUTH_NONE     8'h00
`define FLS_TYPE_SWLINK   8'h01
`define FLS_LINK_P2P      8'h01
`define FLS_VENDOR_MIN    8'hf0
`define FLS_RSVD8         8'h00
`define FLS_RSVD16        16'h0000
`define FLS_RSVD24        24'h000000
`define FLS_RSVD32        32'h00000000
`define FLS_IDX_W0        3'h0
`define FLS_IDX_W1        3'h1
`define FLS_IDX_W2        3'h2
`define FLS_IDX_W3        3'h3
`define FLS_IDX_W4        3'h4
`define FLS_IDX_FLAGS     3'h5
`define FLS_IDX_COUNT     3'h6
`define FLS_IDX_HDR_LAST  3'h5
`define FLS_IDX_STEP      3'h1
`define FLS_IDX_MAX       3'h7
`define FLS_LSR_FIXED     16'h001c
`define FLS_DESC_BYTES    16'h0010
`define FLS_CNT_ONE       32'h00000001
`define FLS_CNT_ZERO      32'h00000000
`define FLS_SEC_NS        1000000000
`define FLS_CLK_NS        4
`endif

/* hdl/fls_rec_fmt.v */
// word formatter for link state record headers and link descriptors
`include "fls_defs.vh"
module fls_rec_fmt (
	descSel,
	wordIdx,
	recType,
	recAge,
	ownDomain,
	advDomain,
	incarnation,
	checksum,
	recLength,
	nbrDomain,
	outPort,
	nbrPort,
	linkType,
	linkCost,
	word
);
	input  wire        descSel;
	input  wire [2:0]  wordIdx;
	input  wire [7:0]  recType;
	input  wire [15:0] recAge;
	input  wire [7:0]  ownDomain;
	input  wire [7:0]  advDomain;
	input  wire [31:0] incarnation;
	input  wire [15:0] checksum;
	input  wire [15:0] recLength;
	input  wire [7:0]  nbrDomain;
	input  wire [23:0] outPort;
	input  wire [23:0] nbrPort;
	input  wire [7:0]  linkType;
	input  wire [15:0] linkCost;
	output reg  [31:0] word;

	always @* begin
		word = `FLS_RSVD32;
		if (descSel) begin
			case (wordIdx)
				`FLS_IDX_W0: word = {`FLS_RSVD24, nbrDomain};
				`FLS_IDX_W1: word = {`FLS_RSVD8, outPort};
				`FLS_IDX_W2: word = {`FLS_RSVD8, nbrPort};
				`FLS_IDX_W3: word = {linkType, `FLS_RSVD8, linkCost};
				default:     word = `FLS_RSVD32;
			endcase
		end else begin
			case (wordIdx)
				`FLS_IDX_W0: word = {recType, `FLS_RSVD8, recAge};
				`FLS_IDX_W1: word = `FLS_RSVD32;
				`FLS_IDX_W2: word = {`FLS_RSVD24, ownDomain};
				`FLS_IDX_W3: word = {`FLS_RSVD24, advDomain};
				`FLS_IDX_W4: word = incarnation;
				`FLS_IDX_FLAGS: word = {checksum, recLength};
				default:     word = `FLS_RSVD32;
			endcase
		end
	end
endmodule

/* hdl/fls_framer.v */
// link state acknowledgement, build and reconfigure fabric framer and parser
`include "fls_defs.vh"
module fls_framer #(
	parameter SEC_CYCLES        = `FLS_SEC_NS / `FLS_CLK_NS,
	parameter [31:0] RJT_CMD    = 32'h01000000,
	parameter [7:0]  RJT_REASON = 8'h00,
	parameter [7:0]  RJT_EXPL_ISO = 8'h00,
	parameter [7:0]  RJT_EXPL_BF  = 8'h00
) (
	input  wire        core_clk,
	input  wire        sys_rst,
	input  wire [7:0]  ownDomain,
	input  wire        cmdLsa,
	input  wire [31:0] lsaCount,
	input  wire        cmdBf,
	input  wire        cmdRcf,
	output wire        cmdReady,
	input  wire        recValid,
	output wire        recReady,
	input  wire [7:0]  recType,
	input  wire [15:0] recBorn,
	input  wire [7:0]  recAdv,
	input  wire [31:0] recIncarn,
	input  wire [15:0] recChecksum,
	input  wire [15:0] recLinks,
	input  wire        bfAcceptEn,
	input  wire        rcfAcceptEn,
	input  wire        purgeDone,
	input  wire        isolateClear,
	output wire [15:0] secCount,
	output reg  [31:0] txData_q,
	output reg         txValid_q,
	output reg         txSop_q,
	output reg         txEop_q,
	output reg  [23:0] txSid_q,
	output reg  [23:0] txDid_q,
	output reg         txExpect_q,
	input  wire        txReady,
	input  wire [31:0] rxData,
	input  wire        rxValid,
	input  wire        rxSop,
	input  wire        rxEop,
	input  wire [23:0] rxSid,
	input  wire [23:0] rxDid,
	output reg         rxLsa_q,
	output reg         rxAcc_q,
	output reg         domListClear_q,
	output reg         purgeTraffic_q,
	output reg         isolated_q,
	output reg  [7:0]  lsuFlags_q,
	input  wire [1:0]  descIdx,
	input  wire [7:0]  descNbrDomain,
	input  wire [23:0] descOutPort,
	input  wire [23:0] descNbrPort,
	input  wire [7:0]  descLinkType,
	input  wire [15:0] descLinkCost,
	output reg  [31:0] descWord_q
);
	// ----------------------------------------
	// states and local signals
	// ----------------------------------------
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_LSA   = 3'h1;
	localparam [2:0] S_REC   = 3'h2;
	localparam [2:0] S_PURGE = 3'h3;
	localparam [2:0] S_RJT   = 3'h4;
	localparam [31:0] SEC_LAST_W = SEC_CYCLES - 1;
	localparam [27:0] SEC_LAST   = SEC_LAST_W[27:0];

	reg  [2:0]  state_q;
	reg  [2:0]  wIdx_q;
	reg  [31:0] recLeft_q;
	reg  [31:0] lsaCount_q;
	reg         purgeAcc_q;
	reg         rjtRcf_q;
	reg         bfPend_q;
	reg         rcfPend_q;
	reg  [27:0] secDiv_q;
	reg  [15:0] sec_q;
	reg  [31:0] rxCmd_q;
	reg  [2:0]  rxIdx_q;
	reg         rxAddrOk_q;
	reg  [31:0] lsaWord;
	wire        ld;
	wire [31:0] recWord;
	wire [31:0] descWord;
	wire [7:0]  sendType;
	wire [7:0]  sendLinkType;
	wire [15:0] recAge;
	wire [15:0] recLength;
	wire [31:0] rxCmdNow;
	wire        rxAddrNow;
	wire        rxOkNow;

	assign ld       = !txValid_q || txReady;
	assign cmdReady = (state_q == S_IDLE) && ld && !bfPend_q && !rcfPend_q;
	assign recReady = (state_q == S_REC) && ld && recValid && (wIdx_q == `FLS_IDX_HDR_LAST);
	assign secCount = sec_q;

	// ----------------------------------------
	// record and descriptor field values
	// ----------------------------------------
	assign sendType = ((recType == `FLS_TYPE_SWLINK) || (recType >= `FLS_VENDOR_MIN)) ?
		recType : `FLS_TYPE_SWLINK;
	assign sendLinkType = ((descLinkType == `FLS_LINK_P2P) || (descLinkType >= `FLS_VENDOR_MIN)) ?
		descLinkType : `FLS_LINK_P2P;
	assign recAge    = sec_q - recBorn;
	assign recLength = `FLS_LSR_FIXED + recLinks * `FLS_DESC_BYTES;

	// checksum passes through untouched while the age moves on
	fls_rec_fmt u_hdr (
		.descSel     (1'b0),
		.wordIdx     (wIdx_q),
		.recType     (sendType),
		.recAge      (recAge),
		.ownDomain   (ownDomain),
		.advDomain   (recAdv),
		.incarnation (recIncarn),
		.checksum    (recChecksum),
		.recLength   (recLength),
		.nbrDomain   (descNbrDomain),
		.outPort     (descOutPort),
		.nbrPort     (descNbrPort),
		.linkType    (sendLinkType),
		.linkCost    (descLinkCost),
		.word        (recWord)
	);

	fls_rec_fmt u_desc (
		.descSel     (1'b1),
		.wordIdx     ({1'b0, descIdx}),
		.recType     (sendType),
		.recAge      (recAge),
		.ownDomain   (ownDomain),
		.advDomain   (recAdv),
		.incarnation (recIncarn),
		.checksum    (recChecksum),
		.recLength   (recLength),
		.nbrDomain   (descNbrDomain),
		.outPort     (descOutPort),
		.nbrPort     (descNbrPort),
		.linkType    (sendLinkType),
		.linkCost    (descLinkCost),
		.word        (descWord)
	);

	// ----------------------------------------
	// acknowledgement preamble words
	// ----------------------------------------
	always @* begin
		lsaWord = `FLS_RSVD32;
		case (wIdx_q)
			`FLS_IDX_W0: lsaWord = `FLS_CMD_LSA;
			`FLS_IDX_W1: lsaWord = {`FLS_FSPF_VER, `FLS_RSVD8, `FLS_AUTH_NONE, `FLS_RSVD8};
			`FLS_IDX_W2: lsaWord = {`FLS_RSVD24, ownDomain};
			`FLS_IDX_FLAGS: lsaWord = {`FLS_RSVD24, lsuFlags_q};
			`FLS_IDX_COUNT: lsaWord = lsaCount_q;
			default:     lsaWord = `FLS_RSVD32;
		endcase
	end

	assign rxCmdNow  = rxSop ? rxData : rxCmd_q;
	assign rxAddrNow = (rxSid == `FLS_FC_ADDR) && (rxDid == `FLS_FC_ADDR);
	assign rxOkNow   = rxSop ? rxAddrNow : rxAddrOk_q;

	// ----------------------------------------
	// transmit, response and receive control
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (sys_rst) begin
			state_q        <= S_IDLE;
			wIdx_q         <= `FLS_IDX_W0;
			recLeft_q      <= `FLS_CNT_ZERO;
			lsaCount_q     <= `FLS_CNT_ZERO;
			purgeAcc_q     <= 1'b0;
			rjtRcf_q       <= 1'b0;
			bfPend_q       <= 1'b0;
			rcfPend_q      <= 1'b0;
			secDiv_q       <= 28'h0000000;
			sec_q          <= `FLS_RSVD16;
			rxCmd_q        <= `FLS_RSVD32;
			rxIdx_q        <= `FLS_IDX_W0;
			rxAddrOk_q     <= 1'b0;
			txData_q       <= `FLS_RSVD32;
			txValid_q      <= 1'b0;
			txSop_q        <= 1'b0;
			txEop_q        <= 1'b0;
			txSid_q        <= `FLS_RSVD24;
			txDid_q        <= `FLS_RSVD24;
			txExpect_q     <= 1'b0;
			rxLsa_q        <= 1'b0;
			rxAcc_q        <= 1'b0;
			domListClear_q <= 1'b0;
			purgeTraffic_q <= 1'b0;
			isolated_q     <= 1'b0;
			lsuFlags_q     <= `FLS_RSVD8;
			descWord_q     <= `FLS_RSVD32;
		end else begin
			descWord_q     <= descWord;
			rxLsa_q        <= 1'b0;
			rxAcc_q        <= 1'b0;
			domListClear_q <= 1'b0;
			if (secDiv_q == SEC_LAST) begin
				secDiv_q <= 28'h0000000;
				sec_q    <= sec_q + 16'h0001;
			end else begin
				secDiv_q <= secDiv_q + 28'h0000001;
			end
			if (isolateClear)
				isolated_q <= 1'b0;
			if (ld) begin
				txValid_q <= 1'b0;
				txSop_q   <= 1'b0;
				txEop_q   <= 1'b0;
			end
			case (state_q)
				S_IDLE: begin
					if (ld) begin
						txSid_q    <= `FLS_FC_ADDR;
						txDid_q    <= `FLS_FC_ADDR;
						txExpect_q <= 1'b0;
						if (rcfPend_q) begin
							rcfPend_q <= 1'b0;
							if (rcfAcceptEn) begin
								purgeTraffic_q <= 1'b1;
								purgeAcc_q     <= 1'b1;
								state_q        <= S_PURGE;
							end else begin
								isolated_q <= 1'b1;
								rjtRcf_q   <= 1'b1;
								txData_q   <= RJT_CMD;
								txValid_q  <= 1'b1;
								txSop_q    <= 1'b1;
								state_q    <= S_RJT;
							end
						end else if (bfPend_q) begin
							bfPend_q  <= 1'b0;
							txValid_q <= 1'b1;
							txSop_q   <= 1'b1;
							if (bfAcceptEn) begin
								txData_q <= `FLS_ACC_WORD;
								txEop_q  <= 1'b1;
							end else begin
								rjtRcf_q <= 1'b0;
								txData_q <= RJT_CMD;
								state_q  <= S_RJT;
							end
						end else if (cmdRcf) begin
							txData_q       <= `FLS_CMD_RCF;
							txValid_q      <= 1'b1;
							txSop_q        <= 1'b1;
							txEop_q        <= 1'b1;
							txExpect_q     <= 1'b1;
							domListClear_q <= 1'b1;
							purgeTraffic_q <= 1'b1;
							purgeAcc_q     <= 1'b0;
							state_q        <= S_PURGE;
						end else if (cmdBf) begin
							// no purge on build fabric
							txData_q       <= `FLS_CMD_BF;
							txValid_q      <= 1'b1;
							txSop_q        <= 1'b1;
							txEop_q        <= 1'b1;
							txExpect_q     <= 1'b1;
							domListClear_q <= 1'b1;
						end else if (cmdLsa) begin
							lsaCount_q <= lsaCount;
							recLeft_q  <= lsaCount;
							txData_q   <= `FLS_CMD_LSA;
							txValid_q  <= 1'b1;
							txSop_q    <= 1'b1;
							txExpect_q <= 1'b0;
							wIdx_q     <= `FLS_IDX_W1;
							state_q    <= S_LSA;
						end
					end
				end
				S_LSA: begin
					if (ld) begin
						txData_q  <= lsaWord;
						txValid_q <= 1'b1;
						if (wIdx_q == `FLS_IDX_COUNT) begin
							wIdx_q <= `FLS_IDX_W0;
							if (lsaCount_q == `FLS_CNT_ZERO) begin
								txEop_q <= 1'b1;
								state_q <= S_IDLE;
							end else begin
								state_q <= S_REC;
							end
						end else begin
							wIdx_q <= wIdx_q + `FLS_IDX_STEP;
						end
					end
				end
				S_REC: begin
					if (ld && recValid) begin
						txData_q  <= recWord;
						txValid_q <= 1'b1;
						if (wIdx_q == `FLS_IDX_HDR_LAST) begin
							wIdx_q    <= `FLS_IDX_W0;
							recLeft_q <= recLeft_q - `FLS_CNT_ONE;
							if (recLeft_q == `FLS_CNT_ONE) begin
								txEop_q <= 1'b1;
								state_q <= S_IDLE;
							end
						end else begin
							wIdx_q <= wIdx_q + `FLS_IDX_STEP;
						end
					end
				end
				S_PURGE: begin
					if (purgeDone && ld) begin
						purgeTraffic_q <= 1'b0;
						state_q        <= S_IDLE;
						if (purgeAcc_q) begin
							txData_q   <= `FLS_ACC_WORD;
							txValid_q  <= 1'b1;
							txSop_q    <= 1'b1;
							txEop_q    <= 1'b1;
							txExpect_q <= 1'b0;
						end
					end
				end
				S_RJT: begin
					if (ld) begin
						txData_q  <= {`FLS_RSVD8, RJT_REASON,
							(rjtRcf_q ? RJT_EXPL_ISO : RJT_EXPL_BF), `FLS_RSVD8};
						txValid_q <= 1'b1;
						txEop_q   <= 1'b1;
						state_q   <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
			// receive side; a new request sets its pending flag after any clear above
			if (rxValid) begin
				if (rxSop) begin
					rxCmd_q    <= rxData;
					rxAddrOk_q <= rxAddrNow;
					rxIdx_q    <= `FLS_IDX_W1;
				end else if (rxIdx_q != `FLS_IDX_MAX) begin
					rxIdx_q <= rxIdx_q + `FLS_IDX_STEP;
				end
				if (!rxSop && rxAddrOk_q && (rxCmd_q == `FLS_CMD_LSU) &&
					(rxIdx_q == `FLS_IDX_FLAGS))
					lsuFlags_q <= rxData[7:0];
				if (rxEop && rxOkNow) begin
					if (rxCmdNow == `FLS_CMD_BF) begin
						bfPend_q       <= 1'b1;
						domListClear_q <= 1'b1;
					end else if (rxCmdNow == `FLS_CMD_RCF) begin
						rcfPend_q      <= 1'b1;
						domListClear_q <= 1'b1;
					end else if (rxCmdNow == `FLS_CMD_LSA) begin
						rxLsa_q <= 1'b1;
					end else if (rxCmdNow == `FLS_ACC_WORD) begin
						rxAcc_q <= 1'b1;
					end
				end
			end
		end
	end
endmodule

/* bench/fls_asserts.sv */
// port assertions for the link state framer
module fls_asserts (
	input wire        core_clk,
	input wire        sys_rst,
	input wire        cmdLsa,
	input wire        cmdBf,
	input wire        cmdRcf,
	input wire        cmdReady,
	input wire        purgeDone,
	input wire        isolateClear,
	input wire [31:0] txData_q,
	input wire        txValid_q,
	input wire        txSop_q,
	input wire        txEop_q,
	input wire [23:0] txSid_q,
	input wire [23:0] txDid_q,
	input wire        txExpect_q,
	input wire        domListClear_q,
	input wire        purgeTraffic_q,
	input wire        isolated_q,
	input wire [1:0]  descIdx,
	input wire [7:0]  descNbrDomain,
	input wire [31:0] descWord_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence bf_take;
		cmdBf && !cmdRcf && cmdReady;
	endsequence
	sequence bf_word;
		txSop_q && txEop_q && txData_q == 32'h01700000;
	endsequence
	bf_frame_a: assert property (bf_take |=> bf_word ##0
		(txExpect_q && domListClear_q && !purgeTraffic_q)) else $error("bf frame wrong");
	rcf_frame_a: assert property (cmdRcf && cmdReady |=> txData_q == 32'h18000000
		&& txEop_q && domListClear_q && purgeTraffic_q) else $error("rcf frame wrong");
	lsa_head_a: assert property (cmdLsa && !cmdBf && !cmdRcf && cmdReady |=>
		txSop_q && !txEop_q && !txExpect_q && txData_q == 32'h16000000) else $error("lsa head");
	fc_addr_a: assert property (txValid_q && txSop_q |->
		txSid_q == 24'hfffffd && txDid_q == 24'hfffffd) else $error("frame address");
	acc_wait_a: assert property (purgeTraffic_q |->
		!(txValid_q && txSop_q && txData_q == 32'h00200000)) else $error("accept early");
	purge_hold_a: assert property (purgeTraffic_q && !purgeDone |=> purgeTraffic_q)
		else $error("purge dropped");
	iso_hold_a: assert property (isolated_q && !isolateClear |=> isolated_q)
		else $error("isolation dropped");
	desc_link_a: assert property (descIdx == 2'h0 |=>
		descWord_q == {24'h0, $past(descNbrDomain)}) else $error("link id word");
endmodule
bind fls_framer fls_asserts fls_asserts_i (.*);

/* bench/fls_nbr_model.sv */
// neighbor fabric controller model on the far side of the link
module fls_nbr_model (
	input  wire         core_clk,
	output logic        txReady,
	output logic [31:0] rxData,
	output logic        rxValid,
	output logic        rxSop,
	output logic        rxEop,
	output logic [23:0] rxSid,
	output logic [23:0] rxDid
);
	timeunit 1ns;
	timeprecision 1ps;
	bit stall;
	initial begin
		{txReady, rxValid, rxSop, rxEop} = 4'h8;
		{rxData, rxSid, rxDid} = '0;
	end
	// random back-pressure when asked
	always @(posedge core_clk)
		txReady <= !stall || $urandom_range(1) == 1;
	// one frame from the neighbor; released lines show inverted data
	task automatic send(input logic [31:0] cmd, input logic [7:0] fl, input int n, input bit bad);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			rxValid <= 1'b1;
			rxSop <= i == 0;
			rxEop <= i == n - 1;
			rxData <= i == 0 ? cmd : i == 5 ? {24'h0, fl} : 32'h0;
			rxSid <= bad ? 24'h0a0b0c : 24'hfffffd;
			rxDid <= 24'hfffffd;
		end
		@(posedge core_clk);
		{rxValid, rxSop, rxEop} <= 3'h0;
		{rxData, rxSid, rxDid} <= ~{rxData, rxSid, rxDid};
	endtask
endmodule

/* bench/testbench.sv */
// self-checking bench for the link state framer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SEC = 400;
	logic core_clk, sys_rst, cmdLsa, cmdBf, cmdRcf, recValid, bfAcceptEn, rcfAcceptEn;
	logic purgeDone, isolateClear, cmdReady, recReady, txValid_q, txSop_q, txEop_q;
	logic txExpect_q, txReady, rxValid, rxSop, rxEop, rxLsa_q, rxAcc_q;
	logic domListClear_q, purgeTraffic_q, isolated_q;
	logic [1:0] descIdx;
	logic [7:0] ownDomain, recType, recAdv, lsuFlags_q, descNbrDomain, descLinkType, fl, lt;
	logic [15:0] recBorn, recChecksum, recLinks, secCount, descLinkCost;
	logic [23:0] txSid_q, txDid_q, rxSid, rxDid, descOutPort, descNbrPort;
	logic [31:0] lsaCount, recIncarn, txData_q, rxData, descWord_q, r0, r1, e;
	logic [32:0] expQ[$];
	logic sopExp = 1'b1;
	int n_fail, checked, cyc, nLsa, nClr, nAcc, eClr;
	fls_framer #(.SEC_CYCLES(SEC)) fls_framer_i (.*);
	fls_nbr_model fls_nbr_model_i (.*);
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask
	function automatic logic [7:0] fix(input logic [7:0] t);
		return (t == 8'h01 || t >= 8'hf0) ? t : 8'h01;
	endfunction
	function automatic void push(input logic [31:0] w, input logic l);
		expQ.push_back({l, w});
	endfunction
	task automatic txOut;
		logic [32:0] w;
		if (expQ.size() == 0) begin
			chk("tx extra", 32'h0, 32'h1);
			return;
		end
		w = expQ.pop_front();
		chk("tx word", w[31:0], txData_q);
		chk("tx sop", {31'h0, sopExp}, {31'h0, txSop_q});
		chk("tx eop", {31'h0, w[32]}, {31'h0, txEop_q});
		sopExp = w[32];
	endtask
	always @(posedge core_clk) begin
		cyc <= sys_rst ? 0 : cyc + 1;
		nLsa <= nLsa + int'(rxLsa_q);
		nClr <= nClr + int'(domListClear_q);
		nAcc <= nAcc + int'(rxAcc_q);
		if (!sys_rst && txValid_q && txReady)
			txOut();
	end
	task automatic idle;
		int t;
		for (t = 0; t < 400 && (expQ.size() > 0 || txValid_q !== 1'b0 || cmdReady !== 1'b1); t++)
			@(posedge core_clk);
		if (t == 400)
			n_fail++;
		#1;
	endtask
	// command held until the edge at which cmdReady is sampled high
	task automatic go(input logic [2:0] k, input logic [31:0] n);
		int t;
		@(posedge core_clk);
		{cmdRcf, cmdBf, cmdLsa} <= k;
		lsaCount <= n;
		t = 0;
		do begin
			@(posedge core_clk);
			t++;
		end while (cmdReady !== 1'b1 && t < 100);
		if (cmdReady !== 1'b1)
			n_fail++;
		{cmdRcf, cmdBf, cmdLsa} <= 3'h0;
	endtask
	task automatic purge;
		@(posedge core_clk);
		purgeDone <= 1'b1;
		for (int t = 0; t < 100 && purgeTraffic_q !== 1'b0; t++)
			@(posedge core_clk);
		if (purgeTraffic_q !== 1'b0)
			n_fail++;
		purgeDone <= 1'b0;
	endtask
	// next record fields land on the very edge that consumes the previous one
	task automatic recs;
		int t;
		@(posedge core_clk);
		for (int r = 0; r < 2; r++) begin
			r0 = $urandom;
			r1 = $urandom;
			lt = r ? 8'hf5 : 8'h02;
			push({fix(lt), 8'h0, 16'd2 + r[15:0]}, 1'b0);
			push(32'h0, 1'b0);
			push({24'h0, ownDomain}, 1'b0);
			push({24'h0, r0[15:8]}, 1'b0);
			push(r1, 1'b0);
			push({r0[31:16], 16'd28 + {12'h0, r0[3:0]} * 16'd16}, r == 1);
			recValid <= 1'b1;
			recType <= lt;
			recBorn <= 16'h0 - r[15:0];
			{recChecksum, recAdv} <= r0[31:8];
			recIncarn <= r1;
			recLinks <= {12'h0, r0[3:0]};
			t = 0;
			do begin
				@(posedge core_clk);
				t++;
			end while (recReady !== 1'b1 && t < 300);
			if (recReady !== 1'b1)
				n_fail++;
		end
		recValid <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4 * SEC + 3000) @(posedge core_clk);
		n_fail++;
		print_verdict();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		{cmdLsa, cmdBf, cmdRcf, recValid, purgeDone, isolateClear, descIdx, lsaCount} = '0;
		{recType, recBorn, recAdv, recIncarn, recChecksum, recLinks, bfAcceptEn} = '0;
		{rcfAcceptEn, descNbrDomain, descOutPort, descNbrPort, descLinkType, descLinkCost} = '0;
		ownDomain = 8'h2a;
		sys_rst = 1'b1;
		r0 = $urandom(32'h997270f4);
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		#1 chk("reset", 32'h0, {28'h0, txValid_q, domListClear_q, purgeTraffic_q, isolated_q});
		for (int i = 0; i < 12; i++) begin
			r0 = $urandom;
			r1 = $urandom;
			lt = (i < 4) ? 8'h01 : (i < 8) ? r0[7:0] : {4'hf, r1[3:0]};
			case (i % 4)
				0: e = {24'h0, r0[31:24]};
				1: e = {8'h0, r0[23:0]};
				2: e = {8'h0, r1[23:0]};
				default: e = {fix(lt), 8'h0, r1[31:16]};
			endcase
			@(posedge core_clk);
			descIdx <= i[1:0];
			{descNbrDomain, descOutPort} <= r0;
			descNbrPort <= r1[23:0];
			descLinkCost <= r1[31:16];
			descLinkType <= lt;
			@(posedge core_clk);
			#1 chk("descriptor", e, descWord_q);
		end
		fl = 8'($urandom);
		fls_nbr_model_i.send(32'h15000000, fl, 8, 1'b0);
		fls_nbr_model_i.send(32'h16000000, 8'h0, 7, 1'b0);
		fls_nbr_model_i.send(32'h00200000, 8'h0, 1, 1'b0);
		repeat (3) @(posedge core_clk);
		#1 chk("lsu flags", {24'h0, fl}, {24'h0, lsuFlags_q});
		chk("lsa seen", 32'd1, nLsa);
		chk("lsa calm", 32'd0, {31'h0, purgeTraffic_q});
		while (cyc < 2 * SEC + 20)
			@(posedge core_clk);
		#1 chk("seconds", 32'd2, {16'h0, secCount});
		push(32'h16000000, 1'b0);
		push(32'h02000000, 1'b0);
		push({24'h0, ownDomain}, 1'b0);
		push(32'h0, 1'b0);
		push(32'h0, 1'b0);
		push({24'h0, fl}, 1'b0);
		push(32'd2, 1'b0);
		fls_nbr_model_i.stall = 1'b1;
		fork
			go(3'b001, 32'd2);
			recs();
		join
		idle();
		fls_nbr_model_i.stall = 1'b0;
		push(32'h01700000, 1'b1);
		go(3'b010, 32'h0);
		eClr++;
		idle();
		push(32'h18000000, 1'b1);
		go(3'b100, 32'h0);
		eClr++;
		repeat (4) @(posedge core_clk);
		#1 chk("tx purge", 32'd1, {31'h0, purgeTraffic_q});
		purge();
		for (int a = 1; a >= 0; a--) begin
			idle();
			@(posedge core_clk);
			bfAcceptEn <= a[0];
			push(a ? 32'h00200000 : 32'h01000000, a[0]);
			if (a == 0)
				push(32'h0, 1'b1);
			fls_nbr_model_i.send(32'h01700000, 8'h0, 1, 1'b0);
			eClr++;
		end
		for (int a = 1; a >= 0; a--) begin
			idle();
			@(posedge core_clk);
			rcfAcceptEn <= a[0];
			push(a ? 32'h00200000 : 32'h01000000, a[0]);
			if (a == 0)
				push(32'h0, 1'b1);
			fls_nbr_model_i.send(32'h18000000, 8'h0, 1, 1'b0);
			eClr++;
			repeat (4) @(posedge core_clk);
			#1 chk("rx purge", a, {31'h0, purgeTraffic_q});
			if (a == 1) begin
				chk("acc held", 32'd1, expQ.size());
				purge();
			end
		end
		idle();
		chk("isolated", 32'd1, {31'h0, isolated_q});
		@(posedge core_clk);
		isolateClear <= 1'b1;
		@(posedge core_clk);
		isolateClear <= 1'b0;
		fls_nbr_model_i.send(32'h01700000, 8'h0, 1, 1'b1);
		repeat (20) @(posedge core_clk);
		#1 chk("isolate off", 32'd0, {31'h0, isolated_q});
		chk("list clears", eClr, nClr);
		chk("accepts seen", 32'd1, nAcc);
		chk("tx left", 32'd0, expQ.size());
		print_verdict();
	end
endmodule
